// [include/rcca_pkg.sv]
// Package for the rotate / convert / compare datapath slice.
// Assumes a single 125 MHz clock and an APB master on the register side.
package rcca_pkg;
  localparam int unsigned RCCA_DATA_W = 32;
  localparam int unsigned RCCA_ADDR_W = 12;

  localparam logic [11:0] RCCA_OFS_CTRL = 12'h000;
  localparam logic [11:0] RCCA_OFS_OPERAND = 12'h004;
  localparam logic [11:0] RCCA_OFS_SOURCE = 12'h008;
  localparam logic [11:0] RCCA_OFS_ACCUM = 12'h00C;
  localparam logic [11:0] RCCA_OFS_HIGHDATA = 12'h010;
  localparam logic [11:0] RCCA_OFS_COUNT = 12'h014;
  localparam logic [11:0] RCCA_OFS_FLAGS = 12'h018;
  localparam logic [11:0] RCCA_OFS_RESULT = 12'h01C;
  localparam logic [11:0] RCCA_OFS_IPTR = 12'h020;
  localparam logic [11:0] RCCA_OFS_STATUS = 12'h024;
  localparam logic [11:0] RCCA_OFS_BRANCH = 12'h028;

  // CTRL fields: [3:0] opcode, [4] word size, [6:5] count source, [12:8] immediate count, [31] go
  localparam int unsigned RCCA_CTRL_OP_LSB = 0;
  localparam int unsigned RCCA_CTRL_WORD_BIT = 4;
  localparam int unsigned RCCA_CTRL_CSRC_LSB = 5;
  localparam int unsigned RCCA_CTRL_IMM_LSB = 8;
  localparam int unsigned RCCA_CTRL_GO_BIT = 31;

  // FLAGS fields
  localparam int unsigned RCCA_FLG_CARRY = 0;
  localparam int unsigned RCCA_FLG_PARITY = 2;
  localparam int unsigned RCCA_FLG_AUX = 4;
  localparam int unsigned RCCA_FLG_ZERO = 6;
  localparam int unsigned RCCA_FLG_SIGN = 7;
  localparam int unsigned RCCA_FLG_DIR = 10;
  localparam int unsigned RCCA_FLG_OVF = 11;

  // BRANCH fields: [0] conditional, [1] when carry set
  localparam int unsigned RCCA_BR_COND_BIT = 0;
  localparam int unsigned RCCA_BR_POL_BIT = 1;

  localparam logic [15:0] RCCA_FLAGS_RST = 16'h0002;
  localparam logic [15:0] RCCA_IPTR_STEP = 16'h0001;
  localparam logic [4:0] RCCA_COUNT_MASK = 5'h1F;
  localparam int unsigned RCCA_IDLE_CYCLES = 2;

  typedef enum logic [3:0] {
    RCCA_OP_ROTATE_LEFT = 4'h0,
    RCCA_OP_ROTATE_RIGHT = 4'h1,
    RCCA_OP_ROTATE_LEFT_THROUGH_CARRY = 4'h2,
    RCCA_OP_ROTATE_RIGHT_THROUGH_CARRY = 4'h3,
    RCCA_OP_WORD_TO_DOUBLE_EXTEND = 4'h4,
    RCCA_OP_BYTE_TO_WORD_EXTEND = 4'h5,
    RCCA_OP_IDLE = 4'h6,
    RCCA_OP_TEST = 4'h7,
    RCCA_OP_COMPARE = 4'h8,
    RCCA_OP_JUMP_IF_CARRY = 4'h9
  } rcca_op_t;

  typedef enum logic [1:0] {
    RCCA_CNT_ONE = 2'h0,
    RCCA_CNT_IMM = 2'h1,
    RCCA_CNT_REG = 2'h2
  } rcca_csrc_t;

  typedef enum logic [2:0] {
    RCCA_ST_IDLE = 3'b001,
    RCCA_ST_BUSY = 3'b010,
    RCCA_ST_DONE = 3'b100
  } rcca_state_t;

  typedef struct packed {
    logic ovf;
    logic dir;
    logic sign;
    logic zero;
    logic aux;
    logic parity;
    logic carry;
  } rcca_flags_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } rcca_apb_req_t;
endpackage : rcca_pkg

// [verilog/rcca_alu.sv]
// Rotate, sign-extend, idle, test and compare datapath with an APB register file.
// Assumes an APB master on pclk; all operations are started by software writes.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Plain rotates recirculate every bit leaving one end into the other end.
// - Rotates change only the carry and overflow flags.
// - Carry holds the last bit rotated out after every rotate.
// - Single-step rotate sets overflow when the top bit changed, else clears it.
// - Multi-step rotate leaves overflow undefined; here it is left unchanged.
// - Rotate count is one, an immediate, or the count register.
// - Rotate left moves top bit out and into bit zero.
// - Rotate right moves bit zero out and into the top bit.
// - Rotate left through carry treats carry as an extra top bit.
// - Rotate right through carry treats carry as an extra bottom bit.
// - Word to double fills high data register with accumulator sign, flags kept.
// - Byte to word copies low byte sign into upper byte, flags kept.
// - Idle is one byte, only advances the instruction pointer.
// - Idle occupies the execution unit for two clock cycles.
// - Test ANDs operands for flags only, never writes back.
// - Test clears overflow and direction, updates sign, zero, parity.
// - Compare subtracts source from destination, updates six flags, keeps operands.
// - Compare uses equal-size operands, both bytes or both words.
// - Unconditional transfers always taken; conditional ones follow earlier flags.
module rcca_alu
  import rcca_pkg::*;
#(
  parameter int unsigned MAX_COUNT = 31
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy,
  output logic done
);

  rcca_state_t state_ff;
  logic [31:0] ctrl_ff;
  logic [15:0] operand_ff;
  logic [15:0] source_ff;
  logic [15:0] accum_ff;
  logic [15:0] highdata_ff;
  logic [7:0] count_ff;
  rcca_flags_t flags_ff;
  logic [15:0] result_ff;
  logic [15:0] iptr_ff;
  logic [1:0] branch_ff;
  logic taken_ff;
  logic [4:0] steps_ff;
  logic [1:0] idle_cnt_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  function automatic logic even_parity(input logic [7:0] v);
    even_parity = ~^v;
  endfunction : even_parity

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge_bytes = r;
  endfunction : merge_bytes

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a <= RCCA_OFS_BRANCH) && (a[1:0] == 2'h0);
  endfunction : addr_known

  rcca_op_t op;
  logic is_word;
  rcca_csrc_t csrc;
  logic [4:0] eff_count;
  logic setup;
  logic wr_access;
  logic rd_access;
  logic go;
  logic top_now;

  assign op = rcca_op_t'(ctrl_ff[RCCA_CTRL_OP_LSB +: 4]);
  assign is_word = ctrl_ff[RCCA_CTRL_WORD_BIT];
  assign csrc = rcca_csrc_t'(ctrl_ff[RCCA_CTRL_CSRC_LSB +: 2]);
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite && pready_ff;
  assign rd_access = psel && penable && !pwrite && pready_ff;
  assign go = wr_access && (paddr == RCCA_OFS_CTRL) && pstrb[3] && pwdata[RCCA_CTRL_GO_BIT]
    && (state_ff == RCCA_ST_IDLE);
  assign top_now = is_word ? operand_ff[15] : operand_ff[7];

  // Effective count from the selected source, masked to five bits
  always_comb
  begin
    unique case (csrc)
      RCCA_CNT_ONE: eff_count = 5'h01;
      RCCA_CNT_IMM: eff_count = ctrl_ff[RCCA_CTRL_IMM_LSB +: 5] & RCCA_COUNT_MASK;
      RCCA_CNT_REG: eff_count = count_ff[4:0] & RCCA_COUNT_MASK;
      default: eff_count = 5'h01;
    endcase
  end

  // Compare and test arithmetic, width-selected
  logic [16:0] diff;
  logic [4:0] diff_nib;
  logic [15:0] and_res;
  logic cmp_sign;
  logic cmp_zero;
  logic cmp_carry;
  logic cmp_ovf;
  logic and_sign;
  logic and_zero;

  always_comb
  begin
    diff = {1'b0, operand_ff} - {1'b0, source_ff};
    diff_nib = {1'b0, operand_ff[3:0]} - {1'b0, source_ff[3:0]};
    and_res = operand_ff & source_ff;
    if (is_word)
    begin
      cmp_sign = diff[15];
      cmp_zero = (diff[15:0] == 16'h0000);
      cmp_carry = diff[16];
      cmp_ovf = (operand_ff[15] != source_ff[15]) && (diff[15] != operand_ff[15]);
      and_sign = and_res[15];
      and_zero = (and_res == 16'h0000);
    end
    else
    begin
      cmp_sign = diff[7];
      cmp_zero = (diff[7:0] == 8'h00);
      cmp_carry = (operand_ff[7:0] < source_ff[7:0]);
      cmp_ovf = (operand_ff[7] != source_ff[7]) && (diff[7] != operand_ff[7]);
      and_sign = and_res[7];
      and_zero = (and_res[7:0] == 8'h00);
    end
  end

  // One rotate step per cycle
  logic [15:0] rot_val;
  logic rot_out;
  always_comb
  begin
    rot_val = operand_ff;
    rot_out = flags_ff.carry;
    unique case (op)
      RCCA_OP_ROTATE_LEFT:
      begin
        rot_out = top_now;
        rot_val = is_word ? {operand_ff[14:0], operand_ff[15]} : {8'h00, operand_ff[6:0], operand_ff[7]};
      end
      RCCA_OP_ROTATE_RIGHT:
      begin
        rot_out = operand_ff[0];
        rot_val = is_word ? {operand_ff[0], operand_ff[15:1]} : {8'h00, operand_ff[0], operand_ff[7:1]};
      end
      RCCA_OP_ROTATE_LEFT_THROUGH_CARRY:
      begin
        rot_out = top_now;
        rot_val = is_word ? {operand_ff[14:0], flags_ff.carry} : {8'h00, operand_ff[6:0], flags_ff.carry};
      end
      RCCA_OP_ROTATE_RIGHT_THROUGH_CARRY:
      begin
        rot_out = operand_ff[0];
        rot_val = is_word ? {flags_ff.carry, operand_ff[15:1]} : {8'h00, flags_ff.carry, operand_ff[7:1]};
      end
      default:
      begin
        rot_val = operand_ff;
        rot_out = flags_ff.carry;
      end
    endcase
  end

  logic is_rotate;
  assign is_rotate = (op == RCCA_OP_ROTATE_LEFT) || (op == RCCA_OP_ROTATE_RIGHT)
    || (op == RCCA_OP_ROTATE_LEFT_THROUGH_CARRY) || (op == RCCA_OP_ROTATE_RIGHT_THROUGH_CARRY);

  // Sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= RCCA_ST_IDLE;
      steps_ff <= 5'h00;
      idle_cnt_ff <= 2'h0;
    end
    else
    begin
      unique case (state_ff)
        RCCA_ST_IDLE:
        begin
          if (go)
          begin
            state_ff <= RCCA_ST_BUSY;
            steps_ff <= 5'h00;
            idle_cnt_ff <= 2'(RCCA_IDLE_CYCLES - 1);
          end
        end
        RCCA_ST_BUSY:
        begin
          if (is_rotate)
          begin
            if (steps_ff >= eff_count)
            begin
              state_ff <= RCCA_ST_DONE;
            end
            else
            begin
              steps_ff <= steps_ff + 5'h01;
            end
          end
          else if (op == RCCA_OP_IDLE)
          begin
            if (idle_cnt_ff == 2'h0)
            begin
              state_ff <= RCCA_ST_DONE;
            end
            else
            begin
              idle_cnt_ff <= idle_cnt_ff - 2'h1;
            end
          end
          else
          begin
            state_ff <= RCCA_ST_DONE;
          end
        end
        RCCA_ST_DONE:
        begin
          state_ff <= RCCA_ST_IDLE;
        end
      endcase
    end
  end

  logic rot_step;
  assign rot_step = (state_ff == RCCA_ST_BUSY) && is_rotate && (steps_ff < eff_count);
  logic exec_once;
  assign exec_once = (state_ff == RCCA_ST_BUSY) && !is_rotate;

  // Operand, accumulator and data registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      operand_ff <= 16'h0000;
      source_ff <= 16'h0000;
      accum_ff <= 16'h0000;
      highdata_ff <= 16'h0000;
      count_ff <= 8'h00;
      result_ff <= 16'h0000;
      ctrl_ff <= 32'h0000_0000;
      branch_ff <= 2'h0;
    end
    else
    begin
      if (wr_access && (state_ff == RCCA_ST_IDLE))
      begin
        unique case (paddr)
          RCCA_OFS_CTRL: ctrl_ff <= merge_bytes(ctrl_ff, pwdata, pstrb) & 32'h7FFF_FFFF;
          RCCA_OFS_OPERAND: operand_ff <= 16'(merge_bytes({16'h0000, operand_ff}, pwdata, pstrb));
          RCCA_OFS_SOURCE: source_ff <= 16'(merge_bytes({16'h0000, source_ff}, pwdata, pstrb));
          RCCA_OFS_ACCUM: accum_ff <= 16'(merge_bytes({16'h0000, accum_ff}, pwdata, pstrb));
          RCCA_OFS_HIGHDATA: highdata_ff <= 16'(merge_bytes({16'h0000, highdata_ff}, pwdata, pstrb));
          RCCA_OFS_COUNT: count_ff <= 8'(merge_bytes({24'h000000, count_ff}, pwdata, pstrb));
          RCCA_OFS_BRANCH: branch_ff <= 2'(merge_bytes({30'h0, branch_ff}, pwdata, pstrb));
          default: ;
        endcase
      end
      if (rot_step)
      begin
        operand_ff <= rot_val;
        result_ff <= rot_val;
      end
      if (exec_once)
      begin
        unique case (op)
          RCCA_OP_WORD_TO_DOUBLE_EXTEND: highdata_ff <= {16{accum_ff[15]}};
          RCCA_OP_BYTE_TO_WORD_EXTEND: accum_ff <= {{8{accum_ff[7]}}, accum_ff[7:0]};
          RCCA_OP_TEST: result_ff <= is_word ? and_res : {8'h00, and_res[7:0]};
          RCCA_OP_COMPARE: result_ff <= is_word ? diff[15:0] : {8'h00, diff[7:0]};
          default: ;
        endcase
      end
    end
  end

  // Flags, instruction pointer and transfer decision
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_ff <= rcca_flags_t'(7'h00);
      iptr_ff <= 16'h0000;
      taken_ff <= 1'b0;
    end
    else
    begin
      if (wr_access && (state_ff == RCCA_ST_IDLE) && (paddr == RCCA_OFS_FLAGS))
      begin
        flags_ff <= '{ovf: pwdata[RCCA_FLG_OVF], dir: pwdata[RCCA_FLG_DIR], sign: pwdata[RCCA_FLG_SIGN],
          zero: pwdata[RCCA_FLG_ZERO], aux: pwdata[RCCA_FLG_AUX], parity: pwdata[RCCA_FLG_PARITY],
          carry: pwdata[RCCA_FLG_CARRY]};
      end
      if (wr_access && (state_ff == RCCA_ST_IDLE) && (paddr == RCCA_OFS_IPTR))
      begin
        iptr_ff <= pwdata[15:0];
      end
      if (rot_step)
      begin
        flags_ff.carry <= rot_out;
        if (eff_count == 5'h01)
        begin
          flags_ff.ovf <= (is_word ? rot_val[15] : rot_val[7]) ^ top_now;
        end
      end
      if (exec_once)
      begin
        unique case (op)
          RCCA_OP_IDLE: iptr_ff <= (idle_cnt_ff == 2'h0) ? iptr_ff + RCCA_IPTR_STEP : iptr_ff;
          RCCA_OP_TEST:
          begin
            flags_ff.ovf <= 1'b0;
            flags_ff.dir <= 1'b0;
            flags_ff.sign <= and_sign;
            flags_ff.zero <= and_zero;
            flags_ff.parity <= even_parity(and_res[7:0]);
          end
          RCCA_OP_COMPARE:
          begin
            flags_ff.ovf <= cmp_ovf;
            flags_ff.sign <= cmp_sign;
            flags_ff.zero <= cmp_zero;
            flags_ff.aux <= diff_nib[4];
            flags_ff.parity <= even_parity(diff[7:0]);
            flags_ff.carry <= cmp_carry;
          end
          RCCA_OP_JUMP_IF_CARRY:
          begin
            taken_ff <= !branch_ff[RCCA_BR_COND_BIT]
              || (flags_ff.carry == branch_ff[RCCA_BR_POL_BIT]);
          end
          default: ;
        endcase
      end
    end
  end

  // APB slave: zero wait states, error on unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= setup;
      pslverr_ff <= setup && !addr_known(paddr);
      if (setup && !pwrite)
      begin
        unique case (paddr)
          RCCA_OFS_CTRL: prdata_ff <= ctrl_ff;
          RCCA_OFS_OPERAND: prdata_ff <= {16'h0000, operand_ff};
          RCCA_OFS_SOURCE: prdata_ff <= {16'h0000, source_ff};
          RCCA_OFS_ACCUM: prdata_ff <= {16'h0000, accum_ff};
          RCCA_OFS_HIGHDATA: prdata_ff <= {16'h0000, highdata_ff};
          RCCA_OFS_COUNT: prdata_ff <= {24'h000000, count_ff};
          RCCA_OFS_FLAGS: prdata_ff <= {20'h00000, flags_ff.ovf, flags_ff.dir, 2'h0, flags_ff.sign,
            flags_ff.zero, 1'b0, flags_ff.aux, 1'b0, flags_ff.parity, 1'b1, flags_ff.carry};
          RCCA_OFS_RESULT: prdata_ff <= {16'h0000, result_ff};
          RCCA_OFS_IPTR: prdata_ff <= {16'h0000, iptr_ff};
          RCCA_OFS_STATUS: prdata_ff <= {29'h0, taken_ff, state_ff == RCCA_ST_DONE, state_ff != RCCA_ST_IDLE};
          RCCA_OFS_BRANCH: prdata_ff <= {30'h0, branch_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
      else if (rd_access)
      begin
        prdata_ff <= prdata_ff;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign busy = state_ff[1];
  assign done = state_ff[2];

endmodule : rcca_alu
`default_nettype wire

// [test/rcca_apb_partner.sv]
// APB master standing in for the decoder and sequencer of the slice.
// Assumes pclk from the bench; the bench calls xfer hierarchically.
`timescale 1ns/1ps
`default_nettype none
module rcca_apb_partner
  import rcca_pkg::*;
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output rcca_apb_req_t req,
  output logic [3:0] pstrb
);
  initial
  begin
    req = '0;
    pstrb = 4'hF;
  end

  // Setup, then access held until pready is sampled high at an edge
  task automatic xfer(input logic wr, input logic [11:0] adr, input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    req <= '{paddr: adr, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer
endmodule : rcca_apb_partner
`default_nettype wire

// [test/rcca_alu_monitor.sv]
// Checker on the APB and status ports of the datapath slice.
// Assumes one clock domain; bound into every instance of the slice.
`timescale 1ns/1ps
`default_nettype none
module rcca_alu_monitor
  import rcca_pkg::*;
#(
  parameter int unsigned MAX_COUNT = 31
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy,
  input wire logic done
);
  logic wr_ok;
  logic go;
  logic [4:0] count_ff;
  logic [5:0] exp_ff;
  logic [5:0] len_ff;
  logic [5:0] rot_len;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign wr_ok = psel && penable && pready && pwrite && !pslverr && !busy && !done;
  assign go = wr_ok && paddr == RCCA_OFS_CTRL && pwdata[31] && pstrb[3];
  assign rot_len = (pwdata[6:5] == 2'h0) ? 6'h02 :
    ((pwdata[6:5] == 2'h1) ? {1'b0, pwdata[12:8]} : {1'b0, count_ff}) + 6'h01;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      count_ff <= 5'h00;
    else if (wr_ok && paddr == RCCA_OFS_COUNT && pstrb[0])
      count_ff <= pwdata[4:0];
  // Busy cycles owed by the operation just started
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      exp_ff <= 6'h00;
    else if (go)
      exp_ff <= (pwdata[3:0] < 4'h4) ? rot_len : ((pwdata[3:0] == 4'h6) ? 6'h02 : 6'h01);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      len_ff <= 6'h00;
    else if (go)
      len_ff <= 6'h00;
    else if (busy)
      len_ff <= len_ff + 6'h01;

  access_ready_a: assert property (psel && !penable |=> pready)
    else $error("pready missing in access");
  ready_pulse_a: assert property (pready |-> (psel && penable) ##1 !pready)
    else $error("pready outside one access cycle");
  unmapped_err_a: assert property (pready && (paddr > RCCA_OFS_BRANCH || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("no error on unmapped address");
  err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  go_busy_a: assert property (go |=> busy && !done)
    else $error("start not followed by busy");
  busy_len_a: assert property (done |-> len_ff == exp_ff)
    else $error("busy length wrong");
  idle_time_a: assert property (go && pwdata[3:0] == 4'h6 |=> busy [*2] ##1 done)
    else $error("idle op timing wrong");
  done_pulse_a: assert property ($fell(busy) |-> done ##1 (!done && !busy))
    else $error("done not a single pulse");

  cover property (go && pwdata[3:0] < 4'h4);
  cover property (go && pwdata[3:0] == 4'h6);
  cover property (pready && pslverr);
endmodule : rcca_alu_monitor

bind rcca_alu rcca_alu_monitor #(.MAX_COUNT(MAX_COUNT)) u_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .done(done));
`default_nettype wire

// [test/rotate_convert_compare_alu_test.sv]
// Self-checking bench for the rotate / convert / compare slice.
// Assumes the partner model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rotate_convert_compare_alu_test;
  import rcca_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, busy, done;
  logic [3:0] pstrb;
  rcca_apb_req_t req;
  int fails = 0;
  int checked = 0;
  always #4 pclk = ~pclk;
  rcca_alu dut (.pclk(pclk), .presetn(presetn), .psel(req.psel), .penable(req.penable), .pwrite(req.pwrite),
    .paddr(req.paddr), .pwdata(req.pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .done(done));
  rcca_apb_partner u_partner (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .req(req),
    .pstrb(pstrb));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    u_partner.xfer(1'b1, a, d, x, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    u_partner.xfer(1'b0, a, 32'h0, d, e);
  endtask : rd
  task automatic wait_done(output int nb);
    int n;
    nb = 0;
    n = 0;
    while (done !== 1'b1 && n < 300)
    begin
      @(posedge pclk);
      n++;
      if (busy === 1'b1)
        nb++;
    end
    if (n >= 300)
      fails++;
  endtask : wait_done
  task automatic run(input logic [3:0] op, input logic wd, input logic [1:0] cs, input logic [4:0] imm, output int nb);
    wr(RCCA_OFS_CTRL, {1'b1, 18'h0, imm, 1'b0, cs, wd, op});
    wait_done(nb);
  endtask : run
  // Returns overflow, carry and the rotated value
  function automatic logic [17:0] rot_ref(input logic [1:0] op, input logic wd, input logic [15:0] v,
                                          input logic c, input logic [4:0] n);
    logic [15:0] r;
    logic t;
    int msb;
    msb = wd ? 15 : 7;
    r = wd ? v : {8'h00, v[7:0]};
    for (int i = 0; i < n; i++)
    begin
      t = op[0] ? r[0] : r[msb];
      r = op[0] ? (r >> 1) : (r << 1);
      if (op[0])
        r[msb] = op[1] ? c : t;
      else
        r[0] = op[1] ? c : t;
      c = t;
    end
    return {r[msb] ^ v[msb], c, r};
  endfunction : rot_ref

  task automatic t_bus();
    logic [31:0] d;
    logic e;
    rd(RCCA_OFS_FLAGS, d);
    chk("flags reset", d, {16'h0, RCCA_FLAGS_RST});
    wr(RCCA_OFS_STATUS, 32'hFFFF_FFFF);
    rd(RCCA_OFS_STATUS, d);
    chk("status", d, 32'h0);
    u_partner.xfer(1'b0, 12'h02C, 32'h0, d, e);
    chk("unmapped", {e, d[30:0]}, 32'h8000_0000);
    u_partner.xfer(1'b1, 12'h006, 32'h1, d, e);
    chk("unaligned", {31'h0, e}, 32'h1);
  endtask : t_bus
  task automatic t_refuse();
    logic [31:0] d;
    int nb;
    wr(RCCA_OFS_OPERAND, 32'h1);
    wr(RCCA_OFS_CTRL, 32'h8000_1420);
    wr(RCCA_OFS_OPERAND, 32'hFF);
    wr(RCCA_OFS_CTRL, 32'h8000_0006);
    wait_done(nb);
    rd(RCCA_OFS_OPERAND, d);
    chk("operand held", d, 32'h10);
    rd(RCCA_OFS_RESULT, d);
    chk("rotate 20", d & 32'hFF, 32'h10);
  endtask : t_refuse
  task automatic t_rotates();
    logic [31:0] d, x, mk;
    logic [17:0] e;
    logic [15:0] v, m;
    logic [11:0] fl;
    logic [4:0] n;
    logic [1:0] cs;
    int nb;
    for (int i = 0; i < 16; i++)
    begin
      cs = (i < 4) ? 2'h0 : ((i < 8 || i > 11) ? 2'h1 : 2'h2);
      n = (i < 4) ? 5'h01 : ((i < 8) ? 5'h03 : ((i < 12) ? 5'h08 : 5'h00));
      m = i[2] ? 16'hFFFF : 16'h00FF;
      v = 16'h9C35 + 16'h02F1 * i[3:0];
      fl = 12'h8D4 | {11'h0, i[1] ^ i[3]};
      e = rot_ref(i[1:0], i[2], v, fl[0], n);
      wr(RCCA_OFS_OPERAND, {16'h0, v});
      wr(RCCA_OFS_FLAGS, {20'h0, fl});
      wr(RCCA_OFS_COUNT, 32'h28);
      run({2'h0, i[1:0]}, i[2], cs, n, nb);
      chk("rotate busy", nb, n + 1);
      rd(RCCA_OFS_OPERAND, d);
      chk("rotate result", d[15:0] & m, e[15:0] & m);
      x = {20'h0, fl[11:1], e[16]} | 32'h2;
      x[11] = e[17];
      mk = (n == 5'h01) ? 32'hFFFF : 32'hF7FF;
      rd(RCCA_OFS_FLAGS, d);
      chk("rotate flags", d & mk, x & mk);
    end
  endtask : t_rotates
  task automatic t_extend();
    logic [31:0] d;
    int nb;
    for (int i = 0; i < 2; i++)
    begin
      wr(RCCA_OFS_FLAGS, 32'h885);
      wr(RCCA_OFS_ACCUM, i ? 32'h8034 : 32'h7F80);
      wr(RCCA_OFS_HIGHDATA, 32'h1234);
      run(RCCA_OP_WORD_TO_DOUBLE_EXTEND, 1'b1, RCCA_CNT_ONE, 5'h00, nb);
      rd(RCCA_OFS_HIGHDATA, d);
      chk("high data", d, i ? 32'hFFFF : 32'h0);
      rd(RCCA_OFS_ACCUM, d);
      chk("accum kept", d, i ? 32'h8034 : 32'h7F80);
      run(RCCA_OP_BYTE_TO_WORD_EXTEND, 1'b0, RCCA_CNT_ONE, 5'h00, nb);
      rd(RCCA_OFS_ACCUM, d);
      chk("accum extend", d, i ? 32'h34 : 32'hFF80);
      rd(RCCA_OFS_FLAGS, d);
      chk("extend flags", d, 32'h887);
    end
  endtask : t_extend
  task automatic t_idle();
    logic [31:0] d;
    int nb;
    wr(RCCA_OFS_IPTR, 32'hFF);
    wr(RCCA_OFS_FLAGS, 32'hC45);
    wr(RCCA_OFS_OPERAND, 32'hA5A5);
    run(RCCA_OP_IDLE, 1'b0, RCCA_CNT_ONE, 5'h00, nb);
    chk("idle busy", nb, RCCA_IDLE_CYCLES);
    rd(RCCA_OFS_IPTR, d);
    chk("iptr", d, 32'h100);
    rd(RCCA_OFS_FLAGS, d);
    chk("idle flags", d, 32'hC47);
    rd(RCCA_OFS_OPERAND, d);
    chk("idle operand", d, 32'hA5A5);
  endtask : t_idle
  task automatic t_test_compare();
    logic [71:0] tab [5] = '{72'h7_1_80F0_8F0F_0084_0CC4, 72'h7_0_000F_00F0_0044_0CC4,
      72'h8_0_0010_0020_0085_08D5, 72'h8_1_8000_0001_0814_08D5, 72'h8_1_1234_1234_0044_08D5};
    logic [31:0] d;
    int nb;
    foreach (tab[i])
    begin
      wr(RCCA_OFS_OPERAND, {16'h0, tab[i][63:48]});
      wr(RCCA_OFS_SOURCE, {16'h0, tab[i][47:32]});
      wr(RCCA_OFS_FLAGS, (tab[i][71:68] == 4'h7) ? 32'hC11 : 32'h8D5);
      run(tab[i][71:68], tab[i][64], RCCA_CNT_ONE, 5'h00, nb);
      rd(RCCA_OFS_FLAGS, d);
      chk("op flags", d & {16'h0, tab[i][15:0]}, {16'h0, tab[i][31:16]});
      rd(RCCA_OFS_OPERAND, d);
      chk("dest kept", d, {16'h0, tab[i][63:48]});
      rd(RCCA_OFS_SOURCE, d);
      chk("source kept", d, {16'h0, tab[i][47:32]});
    end
  endtask : t_test_compare
  task automatic t_branch();
    logic [31:0] d;
    int nb;
    for (int i = 0; i < 8; i++)
    begin
      wr(RCCA_OFS_FLAGS, {31'h0, i[0]});
      wr(RCCA_OFS_BRANCH, {30'h0, i[2:1]});
      run(RCCA_OP_JUMP_IF_CARRY, 1'b0, RCCA_CNT_ONE, 5'h00, nb);
      rd(RCCA_OFS_STATUS, d);
      chk("taken", d[2], !i[1] || (i[0] == i[2]));
    end
  endtask : t_branch

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  initial
  begin
    #100000;
    fails++;
    end_of_test();
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_bus();
    t_refuse();
    t_rotates();
    t_extend();
    t_idle();
    t_test_compare();
    t_branch();
    end_of_test();
  end
endmodule : rotate_convert_compare_alu_test
`default_nettype wire
